// File: design/adcmrc_pkg.sv
// constants shared by the mode, rate and serial control bank
package adcmrc_pkg;
  // register addresses on the serial interface
  localparam logic [12:0] ADDR_MODE    = 13'h0000;
  localparam logic [12:0] ADDR_DIVIND  = 13'h0001;
  localparam logic [12:0] ADDR_RATE    = 13'h0002;
  localparam logic [12:0] ADDR_SDOEDGE = 13'h0004;
  localparam logic [12:0] ADDR_RANDPOL = 13'h0007;
  localparam logic [12:0] ADDR_CALDLY  = 13'h001E;
  // power-on values
  localparam logic [7:0] RST_MODE    = 8'h24;
  localparam logic [7:0] RST_DIVIND  = 8'h0F;
  localparam logic [7:0] RST_RATE    = 8'h00;
  localparam logic [7:0] RST_SDOEDGE = 8'h9F;
  localparam logic [7:0] RST_RANDPOL = 8'h42;
  localparam logic [7:0] RST_CALDLY  = 8'h80;
  // mode register, lower nibble copy
  localparam int BIT_SHUTDOWN = 0;
  localparam int BIT_LSBFIRST = 1;
  localparam int BIT_REINIT   = 2;
  localparam int BIT_STANDBY  = 3;
  // single-bit fields
  localparam int BIT_INDEP    = 7;
  localparam int BIT_SDOEDGE  = 7;
  localparam int BIT_WCKINV   = 7;
  localparam int BIT_CALDLYEN = 6;
  localparam int BIT_RANDOM   = 0;
  // rate codes
  localparam logic [3:0] CODE_MAXDIV   = 4'h9;
  localparam logic [3:0] CODE_ZEROLOW  = 4'hD;
  localparam logic [3:0] CODE_CLKFULL  = 4'hF;
  localparam logic [3:0] CODE_NOCLK    = 4'h0;
  // serial frame layout: 16 instruction bits, 8 data bits
  localparam logic [4:0] FRAME_CMD_BITS  = 5'd16;
  localparam logic [4:0] FRAME_LAST_BIT  = 5'd23;
  localparam logic [4:0] FRAME_BYTE0_END = 5'd7;
  localparam int         CMD_READ_BIT    = 15;
  // start delay step, cycles per code unit
  localparam int CAL_STEP_NS  = 160;
  localparam int CLK_NS       = 10;
  localparam int CAL_STEP_CYC = (CAL_STEP_NS + CLK_NS - 1) / CLK_NS;
endpackage : adcmrc_pkg

// File: design/adcmrc_rate_div.sv
// divides a tick stream by two to the power of a code
`timescale 1ns/1ps
`default_nettype none
module adcmrc_rate_div #(
  parameter int CODE_W = 4,
  parameter int CNT_W  = 9
) (
  input  wire logic              clk_sys,
  input  wire logic              nrst,
  input  wire logic              tickIn,
  input  wire logic [CODE_W-1:0] code,
  input  wire logic              enable,
  output logic                   tickOut_ff
);
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] lastCnt;

  // all-ones in the low code bits marks the last tick of a period
  assign lastCnt = CNT_W'((1 << code) - 1);

  // count incoming ticks, emit one per period; held idle while disabled
  always_ff @(posedge clk_sys) begin
    if (!nrst || !enable) begin
      cnt_ff     <= '0;
      tickOut_ff <= 1'b0;
    end else if (tickIn) begin
      cnt_ff     <= (cnt_ff >= lastCnt) ? '0 : CNT_W'(cnt_ff + 1'b1);
      tickOut_ff <= (cnt_ff >= lastCnt);
    end else begin
      tickOut_ff <= 1'b0;
    end
  end
endmodule // adcmrc_rate_div
`default_nettype wire

// File: design/adcmrc_ctrl.sv
// mode, output rate and serial control register bank of the converter
`timescale 1ns/1ps
`default_nettype none
module adcmrc_ctrl #(
  parameter int DATA_W = 14,
  parameter int STEP_C = adcmrc_pkg::CAL_STEP_CYC
) (
  input  wire logic              clk_sys,
  input  wire logic              nrst,
  input  wire logic              spiSck,
  input  wire logic              spiCsN,
  input  wire logic              spiSdi,
  output logic                   spiSdo,
  output logic                   spiSdoOeN,
  input  wire logic              sampleValid,
  input  wire logic [DATA_W-1:0] sampleData,
  input  wire logic              pllEnable,
  input  wire logic              dllEnable,
  input  wire logic              downConversionMode,
  output logic                   referenceOn,
  output logic                   clocksOn,
  output logic                   standbyOn,
  output logic                   calibInitN,
  output logic                   calibStart,
  output logic                   pllCalStart,
  output logic                   dllReset,
  output logic                   outValid,
  output logic [DATA_W-1:0]      outData,
  output logic                   outputClockPinsP,
  output logic                   outputClockPinsN,
  output logic                   wordClock
);
  // user registers
  logic [7:0] modeReg_ff, divIndReg_ff, rateReg_ff, sdoReg_ff, randPolReg_ff, calDlyReg_ff;
  // pin synchronisers and filtered levels
  logic [2:0] sckSync_ff, csSync_ff, sdiSync_ff;
  logic       sck_ff, csN_ff, sdi_ff;
  logic       sckRise, sckFall;
  // serial frame state
  logic [4:0]  bitCnt_ff;
  logic [7:0]  rxShift_ff;
  logic [7:0]  cmdHigh_ff;
  logic [15:0] cmd_ff;
  logic [7:0]  txShift_ff;
  logic        sdo_ff, sdoOeN_ff;
  logic [7:0]  rxByte, readData, rxNow;
  logic        launchEdge, writeStrobe;
  // decoded controls, lower nibble wins
  logic shutdownOn, lsbFirst, reinitN, standbyBit, running;
  logic reinitPrev_ff, calPending_ff, calStart_ff, pllStart_ff, dllReset_ff;
  logic [15:0] calWait_ff;
  logic dataTick, clkTick, dataZero;
  logic [3:0] clkCode;
  logic clkEnable;
  logic outClk_ff, wck_ff, outValid_ff;
  logic [DATA_W-1:0] outData_ff;
  // read flag position inside the first instruction byte
  localparam int CMD_HI_READ = adcmrc_pkg::CMD_READ_BIT - 8;

  function automatic logic [7:0] bitRev(input logic [7:0] b);
    for (int i = 0; i < 8; i++) bitRev[i] = b[7-i];
  endfunction

  // upper nibble is ignored for control; it only mirrors for reads
  assign shutdownOn = modeReg_ff[adcmrc_pkg::BIT_SHUTDOWN];
  assign lsbFirst   = modeReg_ff[adcmrc_pkg::BIT_LSBFIRST];
  assign reinitN    = modeReg_ff[adcmrc_pkg::BIT_REINIT];
  assign standbyBit = modeReg_ff[adcmrc_pkg::BIT_STANDBY];

  // three stages per pin; a level is taken once stages two and three agree
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      sckSync_ff <= 3'h0;
      csSync_ff  <= 3'h7;
      sdiSync_ff <= 3'h0;
      sck_ff     <= 1'b0;
      csN_ff     <= 1'b1;
      sdi_ff     <= 1'b0;
    end else begin
      sckSync_ff <= {sckSync_ff[1:0], spiSck};
      csSync_ff  <= {csSync_ff[1:0], spiCsN};
      sdiSync_ff <= {sdiSync_ff[1:0], spiSdi};
      if (sckSync_ff[1] == sckSync_ff[2]) sck_ff <= sckSync_ff[2];
      if (csSync_ff[1] == csSync_ff[2]) csN_ff <= csSync_ff[2];
      if (sdiSync_ff[1] == sdiSync_ff[2]) sdi_ff <= sdiSync_ff[2];
    end
  end

  assign sckRise = !csN_ff && !sck_ff && (sckSync_ff[1] == sckSync_ff[2]) && sckSync_ff[2];
  assign sckFall = !csN_ff && sck_ff && (sckSync_ff[1] == sckSync_ff[2]) && !sckSync_ff[2];
  assign rxNow   = {rxShift_ff[6:0], sdi_ff};
  assign rxByte  = lsbFirst ? bitRev(rxNow) : rxNow;
  assign writeStrobe = sckRise && (bitCnt_ff == adcmrc_pkg::FRAME_LAST_BIT)
                       && !cmd_ff[adcmrc_pkg::CMD_READ_BIT];
  assign launchEdge  = sdoReg_ff[adcmrc_pkg::BIT_SDOEDGE] ? sckFall : sckRise;

  // frame receiver: bits taken on rising clock, chip select ends the frame
  always_ff @(posedge clk_sys) begin
    if (!nrst || csN_ff) begin
      bitCnt_ff  <= 5'd0;
      rxShift_ff <= 8'h00;
      cmdHigh_ff <= 8'h00;
      cmd_ff     <= 16'h0000;
    end else if (sckRise) begin
      rxShift_ff <= rxNow;
      if (bitCnt_ff != adcmrc_pkg::FRAME_LAST_BIT) bitCnt_ff <= 5'(bitCnt_ff + 1'b1);
      if (bitCnt_ff == adcmrc_pkg::FRAME_BYTE0_END) cmdHigh_ff <= rxByte;
      if (bitCnt_ff == 5'(adcmrc_pkg::FRAME_CMD_BITS - 1'b1)) cmd_ff <= {cmdHigh_ff, rxByte};
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    unique case ({cmdHigh_ff[4:0], rxByte})
      adcmrc_pkg::ADDR_MODE:    readData = modeReg_ff;
      adcmrc_pkg::ADDR_DIVIND:  readData = divIndReg_ff;
      adcmrc_pkg::ADDR_RATE:    readData = rateReg_ff;
      adcmrc_pkg::ADDR_SDOEDGE: readData = sdoReg_ff;
      adcmrc_pkg::ADDR_RANDPOL: readData = randPolReg_ff;
      adcmrc_pkg::ADDR_CALDLY:  readData = calDlyReg_ff;
      default:                  readData = 8'h00;
    endcase
  end

  // transmitter: loaded after the instruction, shifted on the launch edge
  always_ff @(posedge clk_sys) begin
    if (!nrst || csN_ff) begin
      txShift_ff <= 8'h00;
      sdo_ff     <= 1'b0;
      sdoOeN_ff  <= 1'b1;
    end else if (sckRise && bitCnt_ff == 5'(adcmrc_pkg::FRAME_CMD_BITS - 1'b1)) begin
      txShift_ff <= lsbFirst ? bitRev(readData) : readData;
      sdoOeN_ff  <= !cmdHigh_ff[CMD_HI_READ];
    end else if (launchEdge && bitCnt_ff >= adcmrc_pkg::FRAME_CMD_BITS) begin
      sdo_ff     <= txShift_ff[7];
      txShift_ff <= {txShift_ff[6:0], 1'b0};
    end
  end

  // registers change only by write; mode changes never touch them
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      modeReg_ff    <= adcmrc_pkg::RST_MODE;
      divIndReg_ff  <= adcmrc_pkg::RST_DIVIND;
      rateReg_ff    <= adcmrc_pkg::RST_RATE;
      sdoReg_ff     <= adcmrc_pkg::RST_SDOEDGE;
      randPolReg_ff <= adcmrc_pkg::RST_RANDPOL;
      calDlyReg_ff  <= adcmrc_pkg::RST_CALDLY;
    end else if (writeStrobe) begin
      unique case (cmd_ff[12:0])
        adcmrc_pkg::ADDR_MODE:    modeReg_ff    <= rxByte;
        adcmrc_pkg::ADDR_DIVIND:  divIndReg_ff  <= rxByte;
        adcmrc_pkg::ADDR_RATE:    rateReg_ff    <= rxByte;
        adcmrc_pkg::ADDR_SDOEDGE: sdoReg_ff     <= rxByte;
        adcmrc_pkg::ADDR_RANDPOL: randPolReg_ff <= rxByte;
        adcmrc_pkg::ADDR_CALDLY:  calDlyReg_ff  <= rxByte;
        default:                  ;
      endcase
    end
  end

  // power state decode; soft reset leaves the reference alone
  assign referenceOn = !shutdownOn;
  assign clocksOn    = !shutdownOn && reinitN;
  assign standbyOn   = standbyBit && !shutdownOn;
  assign running     = clocksOn && !standbyBit;
  assign calibInitN  = reinitN;

  // leaving soft reset waits the start delay, then fires calibration
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      reinitPrev_ff <= 1'b1;
      calPending_ff <= 1'b0;
      calWait_ff    <= 16'h0000;
      calStart_ff   <= 1'b0;
      pllStart_ff   <= 1'b0;
      dllReset_ff   <= 1'b0;
    end else begin
      reinitPrev_ff <= reinitN;
      calStart_ff   <= 1'b0;
      pllStart_ff   <= 1'b0;
      dllReset_ff   <= 1'b0;
      if (!reinitN) begin
        calPending_ff <= 1'b0;
      end else if (!reinitPrev_ff) begin
        calPending_ff <= 1'b1;
        calWait_ff    <= randPolReg_ff[adcmrc_pkg::BIT_CALDLYEN]
                         ? 16'(calDlyReg_ff * STEP_C) : 16'h0000;
        dllReset_ff   <= dllEnable;
      end else if (calPending_ff && calWait_ff == 16'h0000) begin
        calPending_ff <= 1'b0;
        calStart_ff   <= 1'b1;
        pllStart_ff   <= pllEnable;
      end else if (calPending_ff) begin
        calWait_ff <= 16'(calWait_ff - 1'b1);
      end
    end
  end
  assign calibStart  = calStart_ff;
  assign pllCalStart = pllStart_ff;
  assign dllReset    = dllReset_ff;

  // clock code follows the data code unless the independent enable is set
  always_comb begin
    clkCode   = 4'h0;
    clkEnable = 1'b0;
    if (divIndReg_ff[adcmrc_pkg::BIT_INDEP]) begin
      if (rateReg_ff[3:0] == adcmrc_pkg::CODE_CLKFULL) begin
        clkEnable = 1'b1;
      end else if (rateReg_ff[3:0] != adcmrc_pkg::CODE_NOCLK
                   && rateReg_ff[3:0] <= adcmrc_pkg::CODE_MAXDIV) begin
        clkCode   = rateReg_ff[3:0];
        clkEnable = 1'b1;
      end
    end else if (rateReg_ff[7:4] <= adcmrc_pkg::CODE_MAXDIV) begin
      clkCode   = rateReg_ff[7:4];
      clkEnable = 1'b1;
    end
  end
  assign dataZero = rateReg_ff[7:4] >= adcmrc_pkg::CODE_ZEROLOW;

  adcmrc_rate_div u_dataDiv (
    .clk_sys    (clk_sys),
    .nrst       (nrst),
    .tickIn     (sampleValid),
    .code       (rateReg_ff[7:4] > adcmrc_pkg::CODE_MAXDIV ? 4'h0 : rateReg_ff[7:4]),
    .enable     (running),
    .tickOut_ff (dataTick)
  );

  adcmrc_rate_div u_clkDiv (
    .clk_sys    (clk_sys),
    .nrst       (nrst),
    .tickIn     (sampleValid),
    .code       (clkCode),
    .enable     (clkEnable && clocksOn),
    .tickOut_ff (clkTick)
  );

  // output words; the divider tick lags sampleValid by one cycle, so sampleData is taken a cycle late, a known limit
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      outValid_ff <= 1'b0;
      outData_ff  <= '0;
      wck_ff      <= 1'b0;
    end else begin
      outValid_ff <= dataTick && running;
      if (!running) begin
        outData_ff <= '0;
      end else if (dataTick) begin
        wck_ff <= !wck_ff;
        if (dataZero) outData_ff <= '0;
        else if (randPolReg_ff[adcmrc_pkg::BIT_RANDOM])
          outData_ff <= sampleData ^ {{(DATA_W-1){sampleData[0]}}, 1'b0};
        else outData_ff <= sampleData;
      end
    end
  end

  // output clock toggles per divided tick; held low on no-clock codes
  always_ff @(posedge clk_sys) begin
    if (!nrst || !clkEnable || !clocksOn) outClk_ff <= 1'b0;
    else if (clkTick) outClk_ff <= !outClk_ff;
  end

  assign outValid         = outValid_ff;
  assign outData          = outData_ff;
  assign outputClockPinsP = outClk_ff;
  assign outputClockPinsN = !outClk_ff;
  assign wordClock        = wck_ff ^ (downConversionMode
                            && randPolReg_ff[adcmrc_pkg::BIT_WCKINV]);
  assign spiSdo           = sdo_ff;
  assign spiSdoOeN        = sdoOeN_ff;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  // checks sit on the decoded controls, so a broken decode shows at once
  a_lower_nibble_wins: assert property (clocksOn == (!modeReg_ff[0] && modeReg_ff[2]))
    else $error("clock enable not from lower nibble");
  a_poweroff_ref: assert property (modeReg_ff[0] |-> !referenceOn && !clocksOn)
    else $error("power-off left reference or clocks on");
  a_reset_noout: assert property (!reinitN |=> !outValid && outData == '0)
    else $error("output during soft reset");
  a_standby_refon: assert property (standbyBit && !shutdownOn |-> referenceOn && standbyOn)
    else $error("standby state wrong");
  a_regs_stable: assert property (!writeStrobe |=> $stable(rateReg_ff) && $stable(modeReg_ff))
    else $error("register changed without write");
  a_zero_codes: assert property (dataZero && running ##1 outValid |-> outData == '0)
    else $error("zero code passed data");
  a_noclock_static: assert property (!clkEnable |=> !outputClockPinsP && outputClockPinsN)
    else $error("clock present on no-clock code");
  a_cal_nodelay: assert property ($rose(reinitN) && !randPolReg_ff[6] ##1 reinitN
                                  |-> ##1 calibStart)
    else $error("calibration not started promptly");
  a_cal_dll: assert property ($rose(reinitN) && dllEnable |=> dllReset)
    else $error("dll reset missing");
  a_wck_invert: assert property ($changed(downConversionMode && randPolReg_ff[7])
                                 && $stable(wck_ff) |-> $changed(wordClock))
    else $error("word clock polarity wrong");
  a_read_drives: assert property (sckRise && cmdHigh_ff[CMD_HI_READ]
                                  && bitCnt_ff == 5'(adcmrc_pkg::FRAME_CMD_BITS - 1'b1)
                                  |=> !spiSdoOeN)
    else $error("read left sdo undriven");
  a_standby_noout: assert property (standbyBit |=> !outValid)
    else $error("output word during standby");
  a_softreset_nocal: assert property (!reinitN |=> !calibStart && !pllCalStart)
    else $error("calibration fired in soft reset");
  a_data_full: assert property (running && sampleValid && rateReg_ff[7:4] == 4'h0
                                |=> dataTick)
    else $error("full speed data tick missing");
  a_clk_full: assert property (clocksOn && sampleValid && divIndReg_ff[7]
                               && rateReg_ff[3:0] == adcmrc_pkg::CODE_CLKFULL |=> clkTick)
    else $error("full speed output clock tick missing");

  // main scenarios: write, calibration, read, words, reversed read
  c_write: cover property (writeStrobe);
  c_calib: cover property (calibStart);
  c_read: cover property (!spiSdoOeN ##1 launchEdge);
  c_outword: cover property (outValid && randPolReg_ff[0]);
  c_lsbread: cover property (lsbFirst && !spiSdoOeN);
endmodule // adcmrc_ctrl
`default_nettype wire

// File: testbench/adcmrc_spi_host.sv
// host-side serial controller model that sends one register per frame
`timescale 1ns/1ps
`default_nettype none
module adcmrc_spi_host (
  input  wire logic clk_sys,
  input  wire logic spiSdo,
  input  wire logic spiSdoOeN,
  output logic      spiSck,
  output logic      spiCsN,
  output logic      spiSdi
);
  // half period kept above the device's four-cycle sck filter
  localparam int HALF = 6;
  // serial clock stands low outside frames
  initial begin
    spiSck = 1'b0;
    spiCsN = 1'b1;
    spiSdi = 1'b1;
  end
  // each byte goes msb first, or reversed when lsb first is in force
  task automatic xfer(input logic rd, input logic [12:0] addr, input logic [7:0] wdata,
                      input logic lsb, input logic fallEdge, output logic [7:0] rdata);
    logic [7:0] b [3];
    int         k;
    b[0]  = {rd, 2'b00, addr[12:8]};
    b[1]  = addr[7:0];
    b[2]  = wdata;
    rdata = 8'h00;
    @(posedge clk_sys) spiCsN <= 1'b0;
    repeat (HALF) @(posedge clk_sys);
    for (int i = 0; i < 24; i++) begin
      k = lsb ? i % 8 : 7 - i % 8;
      spiSdi <= b[i / 8][k];
      repeat (HALF) @(posedge clk_sys);
      // a bit that is not driven reads as unknown, so a late enable shows
      if (i >= 16 && fallEdge) rdata[k] = spiSdoOeN ? 1'bx : spiSdo;
      spiSck <= 1'b1;
      repeat (HALF) @(posedge clk_sys);
      if (i >= 16 && !fallEdge) rdata[k] = spiSdoOeN ? 1'bx : spiSdo;
      spiSck <= 1'b0;
    end
    repeat (HALF) @(posedge clk_sys);
    spiCsN <= 1'b1;
    spiSdi <= ~spiSdi;  // released line shows the inverse of its last bit
    repeat (HALF) @(posedge clk_sys);
  endtask
endmodule // adcmrc_spi_host
`default_nettype wire

// File: testbench/test_adc_mode_output_rate_ctrl.sv
// self-checking bench for the mode, rate and serial control bank
`timescale 1ns/1ps
`default_nettype none
module test_adc_mode_output_rate_ctrl;
  localparam logic [13:0] SMP = 14'h2a5b;
  logic        clk_sys, nrst, spiSck, spiCsN, spiSdi, spiSdo, spiSdoOeN, sampleValid;
  logic        pllEnable, dllEnable, downConversionMode, referenceOn, clocksOn, standbyOn;
  logic        calibInitN, calibStart, pllCalStart, dllReset, outValid, wordClock;
  logic        outputClockPinsP, outputClockPinsN, lastP, lastInit, w0;
  logic [13:0] sampleData, outData, lastData;
  int          n_fail = 0, checks = 0, cyc = 0, nValid = 0, nTog = 0, nZero = 0, nBad = 0;
  int          nDll = 0, nPll = 0, tRise = 0, tCal = 0, d4, v0, p0, z0, b0;
  // power-on table; 0x03 is unmapped
  logic [12:0] rstA [7] = '{13'h0000, 13'h0001, 13'h0002, 13'h0004, 13'h0007, 13'h001e, 13'h0003};
  logic [7:0]  rstV [7] = '{8'h24, 8'h0f, 8'h00, 8'h9f, 8'h42, 8'h80, 8'h00};
  // rate cases; data codes 1010 to 1100 are never sent
  logic [7:0]  rtR  [13] = '{8'h00, 8'h10, 8'h90, 8'hd0, 8'he0, 8'hf0, 8'h0f, 8'h02, 8'h09,
                             8'h0e, 8'h0a, 8'h00, 8'h0e};
  int          rtV  [13] = '{1024, 512, 2, 1024, 1024, 1024, 1024, 1024, 1024, 1024, 1024, 1024, 1024};
  int          rtT  [13] = '{1024, 512, 2, -1, -1, -1, 1024, 256, 2, 0, 0, 0, 1024};

  adcmrc_ctrl #(.DATA_W(14), .STEP_C(1)) i_adcmrc_ctrl (
    .clk_sys(clk_sys), .nrst(nrst), .spiSck(spiSck), .spiCsN(spiCsN), .spiSdi(spiSdi),
    .spiSdo(spiSdo), .spiSdoOeN(spiSdoOeN), .sampleValid(sampleValid), .sampleData(sampleData),
    .pllEnable(pllEnable), .dllEnable(dllEnable), .downConversionMode(downConversionMode),
    .referenceOn(referenceOn), .clocksOn(clocksOn), .standbyOn(standbyOn),
    .calibInitN(calibInitN), .calibStart(calibStart), .pllCalStart(pllCalStart),
    .dllReset(dllReset), .outValid(outValid), .outData(outData),
    .outputClockPinsP(outputClockPinsP), .outputClockPinsN(outputClockPinsN),
    .wordClock(wordClock));
  adcmrc_spi_host i_adcmrc_spi_host (
    .clk_sys(clk_sys), .spiSdo(spiSdo), .spiSdoOeN(spiSdoOeN), .spiSck(spiSck),
    .spiCsN(spiCsN), .spiSdi(spiSdi));

  // 100 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // event counters; only differences over a test window are compared
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    lastP <= outputClockPinsP;
    lastInit <= calibInitN;
    if (outValid === 1'b1) begin
      nValid <= nValid + 1;
      lastData <= outData;
      if (outData === 14'h0000) nZero <= nZero + 1;
    end
    if (outputClockPinsP !== lastP) nTog <= nTog + 1;
    if (outputClockPinsN !== ~outputClockPinsP) nBad <= nBad + 1;
    if (dllReset === 1'b1) nDll <= nDll + 1;
    if (pllCalStart === 1'b1) nPll <= nPll + 1;
    if (calibInitN === 1'b1 && lastInit === 1'b0) tRise <= cyc;
    if (calibStart === 1'b1) tCal <= cyc;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  // divider phase at a window edge may add or drop one event
  task automatic near(input string nm, input int e, input int g);
    checks++;
    if (g < e - 1 || g > e + 1) begin
      n_fail++;
      $display("wrong value %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d, input logic lsb = 1'b0);
    logic [7:0] q;
    i_adcmrc_spi_host.xfer(1'b0, a, d, lsb, 1'b1, q);
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic rd(input logic [12:0] a, input logic [7:0] e, input logic lsb = 1'b0,
                    input logic fe = 1'b1);
    logic [7:0] q;
    i_adcmrc_spi_host.xfer(1'b1, a, 8'h00, lsb, fe, q);
    chk($sformatf("register %0h", a), 16'(e), 16'(q));
  endtask
  task automatic run(input int n, input logic [13:0] d);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys) sampleValid <= 1'b1;
      sampleData <= d;
      @(posedge clk_sys) sampleValid <= 1'b0;
    end
    repeat (6) @(posedge clk_sys);
  endtask

  // a hung handshake ends the run through the same verdict
  initial begin
    repeat (90000) @(posedge clk_sys);
    n_fail++;
    $display("wrong value run length expected done seen hang");
    tally_and_finish();
  end

  initial begin
    nrst = 1'b0;
    sampleValid = 1'b0;
    sampleData = 14'h0000;
    pllEnable = 1'b1;
    dllEnable = 1'b1;
    downConversionMode = 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    foreach (rstA[i]) rd(rstA[i], rstV[i]); // power-on values
    chk("referenceOn", 16'h0001, 16'(referenceOn));
    wr(13'h0003, 8'h55);
    rd(13'h0003, 8'h00);
    wr(13'h0002, 8'h35);
    // disagreeing nibbles: the lower copy decides
    wr(13'h0000, 8'h25);
    chk("referenceOn", 16'h0000, 16'(referenceOn)); // shutdown
    chk("clocksOn", 16'h0000, 16'(clocksOn)); // clocks off
    rd(13'h0000, 8'h25); // both nibbles kept
    wr(13'h0000, 8'ha0); // shutdown left with soft reset
    chk("referenceOn", 16'h0001, 16'(referenceOn)); // upper copy ignored
    chk("calibInitN", 16'h0000, 16'(calibInitN)); // held in init
    chk("clocksOn", 16'h0000, 16'(clocksOn)); // soft reset clocks
    v0 = nValid;
    run(8, SMP);
    chk("soft reset words", 16'h0000, 16'(nValid - v0)); // no output
    chk("soft reset word", 16'h0000, 16'(outData)); // no output
    wr(13'h0000, 8'h2c);
    chk("standbyOn", 16'h0001, 16'(standbyOn)); // standby set
    chk("ref and clk", 16'h0003, 16'({referenceOn, clocksOn})); // stay on
    wr(13'h0000, 8'h20); // standby left with soft reset
    rd(13'h0002, 8'h35); // user value survives
    // start delay: two codes for the slope, then with the delay disabled
    for (int i = 0; i < 3; i++) begin
      wr(13'h0007, i == 2 ? 8'h02 : 8'h42); // factory bits left as found
      wr(13'h001e, i == 0 ? 8'h04 : 8'h80);
      wr(13'h0000, 8'h20);
      v0 = nDll;
      p0 = nPll;
      wr(13'h0000, 8'h24);
      repeat (200) @(posedge clk_sys);
      chk("dll resets", 16'h0001, 16'(nDll - v0)); // one per rise
      chk("pll starts", 16'h0001, 16'(nPll - p0)); // one per rise
      if (i == 0) d4 = tCal - tRise;
      if (i == 1) chk("delay slope", 16'h007c, 16'(tCal - tRise - d4)); // linear
      if (i == 2) chk("undelayed", 16'h0002, 16'(tCal - tRise)); // ignored
    end
    // bit order and launch edge
    wr(13'h0000, 8'h66);
    rd(13'h0004, 8'h9f, 1'b1); // lsb first
    wr(13'h0000, 8'h24, 1'b1);
    rd(13'h0000, 8'h24); // msb first again
    wr(13'h0004, 8'h1f);
    rd(13'h0004, 8'h1f, 1'b0, 1'b0); // rising launch
    wr(13'h0004, 8'h9f);
    rd(13'h0004, 8'h9f); // falling launch
    b0 = nBad;
    foreach (rtR[i]) begin
      wr(13'h0001, i >= 6 && i <= 11 ? 8'h8f : 8'h0f);
      wr(13'h0002, rtR[i]);
      v0 = nValid;
      p0 = nTog;
      z0 = nZero;
      run(1024, SMP);
      near("output words", rtV[i], nValid - v0); // data divider
      if (rtT[i] >= 0) near("clock edges", rtT[i], nTog - p0);
      chk("zero words", 16'(rtR[i][7:4] >= 4'hd ? nValid - v0 : 0), 16'(nZero - z0));
    end
    chk("pin pair", 16'h0000, 16'(nBad - b0)); // pins complementary
    wr(13'h0001, 8'h0f);
    wr(13'h0002, 8'h00);
    wr(13'h0007, 8'h43);
    run(4, SMP);
    chk("scrambled", 16'({SMP[13:1] ^ {13{SMP[0]}}, SMP[0]}), 16'(lastData)); // on
    wr(13'h0007, 8'h42);
    run(4, SMP);
    chk("plain word", 16'(SMP), 16'(lastData)); // off
    wr(13'h0007, 8'hc2);
    w0 = wordClock;
    @(posedge clk_sys) downConversionMode <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk("word clock", 16'(!w0), 16'(wordClock)); // inverted
    wr(13'h0007, 8'h42);
    chk("word clock", 16'(w0), 16'(wordClock)); // not inverted
    tally_and_finish();
  end
endmodule // test_adc_mode_output_rate_ctrl
`default_nettype wire
